//--- shared/tsync_pkg.sv
`default_nettype none
package tsync_pkg;
	localparam int PADDR_W = 8;
	localparam int PDATA_W = 32;
	localparam int CNT_W = 16;
	localparam logic [PADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [PADDR_W-1:0] ADDR_MASTER = 8'h04;
	localparam logic [PADDR_W-1:0] ADDR_SLAVE = 8'h08;
	localparam logic [PADDR_W-1:0] ADDR_CHAN = 8'h0c;
	localparam logic [PADDR_W-1:0] ADDR_POLARITY = 8'h10;
	localparam logic [PADDR_W-1:0] ADDR_EVENT = 8'h14;
	localparam logic [PADDR_W-1:0] ADDR_FLAGS = 8'h18;
	localparam logic [PADDR_W-1:0] ADDR_COUNT = 8'h1c;
	localparam logic [PADDR_W-1:0] ADDR_PRESCALE = 8'h20;
	localparam logic [PADDR_W-1:0] ADDR_RELOAD = 8'h24;
	localparam logic [PADDR_W-1:0] ADDR_COMPARE1 = 8'h28;
	localparam logic [PADDR_W-1:0] ADDR_CAPTURE1 = 8'h2c;
	localparam int CEN_BIT = 0;
	localparam int MMS_LSB = 4;
	localparam int SMS_LSB = 0;
	localparam int TS_LSB = 4;
	localparam int MSM_BIT = 7;
	localparam int ETF_LSB = 8;
	localparam int ETPS_LSB = 12;
	localparam int ECE_BIT = 14;
	localparam int ETP_BIT = 15;
	localparam int CC1S_LSB = 0;
	localparam int IC1F_LSB = 4;
	localparam int CC2S_LSB = 8;
	localparam int IC2F_LSB = 12;
	localparam int CC1P_BIT = 1;
	localparam int CC2P_BIT = 5;
	localparam int UG_BIT = 0;
	localparam int UIF_BIT = 0;
	localparam int TIF_BIT = 6;
	localparam logic [CNT_W-1:0] RELOAD_RESET = 16'hffff;
	localparam logic [3:0] FILTER_OFF = 4'h0;
	localparam logic [1:0] CAPSRC_OWN = 2'h1;
	localparam logic [1:0] CAPSRC_OTHER = 2'h2;
	typedef enum logic [2:0] {SLAVE_OFF = 3'h0, SLAVE_RESET = 3'h4, SLAVE_GATED = 3'h5,
		SLAVE_TRIGGER = 3'h6, SLAVE_EXTCLK1 = 3'h7} slave_mode_e;
	typedef enum logic [2:0] {TRIG_INTERNAL = 3'h0, TRIG_CH1_EDGE = 3'h4, TRIG_CH1 = 3'h5,
		TRIG_CH2 = 3'h6, TRIG_EXT = 3'h7} trig_source_e;
	typedef enum logic [2:0] {MASTER_RESET = 3'h0, MASTER_ENABLE = 3'h1,
		MASTER_UPDATE = 3'h2, MASTER_COMPARE1 = 3'h4} master_mode_e;
endpackage
`default_nettype wire

//--- shared/cond_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
	logic level;
	logic rise;
	logic fall;
	modport src(output level, output rise, output fall);
	modport dst(input level, input rise, input fall);
endinterface
`default_nettype wire

//--- hw/reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
	input wire logic clk,
	input wire logic nrstIn,
	output logic nrstOut
);
	typedef struct packed {
		logic stage1;
		logic stage2;
	} sync_s;
	sync_s s;
	sync_s next_s;
	always_comb begin
		next_s.stage1 = 1'b1;
		next_s.stage2 = s.stage1;
	end
	always_ff @(posedge clk or negedge nrstIn) begin
		if (!nrstIn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign nrstOut = s.stage2;
endmodule // reset_sync
`default_nettype wire

//--- hw/input_conditioner.sv
`timescale 1ns/1ps
`default_nettype none
module input_conditioner (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic pinIn,
	input wire logic [3:0] filterLen,
	input wire logic invert,
	input wire logic [1:0] prescale,
	cond_if.src out
);
	import tsync_pkg::*;
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic filt;
		logic prev;
		logic [3:0] stable;
		logic [2:0] div;
		logic rise;
		logic fall;
	} cond_s;
	cond_s s;
	cond_s next_s;
	logic sample;
	logic rawRise;
	logic [2:0] divMask;
	always_comb begin
		next_s = s;
		next_s.sync1 = pinIn;
		next_s.sync2 = s.sync1;
		sample = s.sync2 ^ invert;
		if (filterLen == FILTER_OFF) begin
			next_s.filt = sample;
			next_s.stable = '0;
		end else if (sample == s.filt) begin
			next_s.stable = '0;
		end else if (s.stable + 4'h1 >= filterLen) begin
			next_s.filt = sample;
			next_s.stable = '0;
		end else begin
			next_s.stable = s.stable + 4'h1;
		end
		next_s.prev = s.filt;
		rawRise = s.filt && !s.prev;
		// one pulse per 1, 2, 4 or 8 rising edges
		divMask = 3'((4'h1 << prescale) - 4'h1);
		next_s.rise = rawRise && (s.div == divMask);
		next_s.fall = !s.filt && s.prev;
		if (rawRise) begin
			next_s.div = (s.div == divMask) ? 3'h0 : s.div + 3'h1;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
	assign out.level = s.filt;
	assign out.rise = s.rise;
	assign out.fall = s.fall;
endmodule // input_conditioner
`default_nettype wire

//--- hw/timer_slave_trigger_and_sync.sv
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Slave mode 110: trigger edge starts counter and sets trigger flag.
// - Trigger select 110 routes filtered channel 2, 101 channel 1.
// - Trigger edges pass resynchronising stages, so counting starts a few cycles late; the internal trigger input is taken without them.
// - Channel filter value 0000 passes edges unfiltered.
// - Channel polarity 0 means non-inverted, rising edges active.
// - Capture source 01 uses own pin; capture path never touches the trigger.
// - External clock 2 combines with reset, gated, trigger; not with clock mode 1.
// - External clock enable 1 makes conditioned external trigger the count clock.
// - External trigger: filter 0000 none, prescale 00 none, polarity 0 rising.
// - Clock 2 plus trigger mode: channel 1 edge starts, external edges count.
// - A master timer can reset, start, stop or clock the other timer.
// - Master mode 010 pulses trigger output on each update event.
// - Master mode 001 puts the counter enable on the trigger output.
// - Master mode 1xx outputs compare reference; its rising edge clocks a slave.
// - Slave mode 111 counts each rising edge of the selected trigger.
// - Gated mode 101 counts only while the trigger level is high.
// - Gating touches only the enable, never the counter clock.
// - Trigger sets the counter enable bit; it stays until software clears it.
// - Update generation write reinitialises counter and prescaler.
// - Software writes to the counter load a new count.
// - Master/slave bit delays own enable so both timers start aligned.
// - Internal trigger input comes from the other timer's trigger output.
// - Writing 1 to a flag bit clears it.
module timer_slave_trigger_and_sync #(
	parameter int CNT_W = tsync_pkg::CNT_W,
	parameter int MSM_DELAY = 2
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tsync_pkg::PADDR_W-1:0] paddr,
	input wire logic [tsync_pkg::PDATA_W-1:0] pwdata,
	output logic pready,
	output logic [tsync_pkg::PDATA_W-1:0] prdata,
	output logic pslverr,
	input wire logic chan1TimerInput,
	input wire logic chan2TimerInput,
	input wire logic externalTriggerPin,
	input wire logic internalTriggerInput,
	output logic triggerOutput,
	output logic chan1CompareReference
);
	import tsync_pkg::*;

	typedef struct packed {
		logic cen;
		logic [2:0] mms;
		logic [2:0] sms;
		logic [2:0] ts;
		logic msm;
		logic [3:0] etf;
		logic [1:0] etps;
		logic ece;
		logic etp;
		logic [1:0] cc1s;
		logic [3:0] ic1f;
		logic [1:0] cc2s;
		logic [3:0] ic2f;
		logic cc1p;
		logic cc2p;
		logic uif;
		logic tif;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] psc;
		logic [CNT_W-1:0] pscCnt;
		logic [CNT_W-1:0] arr;
		logic [CNT_W-1:0] ccr1;
		logic [CNT_W-1:0] capt1;
		logic [MSM_DELAY-1:0] runDly;
		logic trgiPrev;
		logic trigger_output;
		logic ocRef;
		logic pready;
		logic pslverr;
		logic [PDATA_W-1:0] prdata;
	} regs_s;

	regs_s s;
	regs_s next_s;
	logic rstn;
	logic trgiLevel;
	logic trgiRise;
	logic runEnable;
	logic effRun;
	logic countTick;
	logic cntStep;
	logic uevPulse;
	logic ugEvent;
	logic wrEn;
	logic wrCnt;
	logic tifSet;
	logic tifClr;
	logic capEdge;
	logic setup;

	cond_if ch1If();
	cond_if ch2If();
	cond_if extIf();

	reset_sync resetSync (
		.clk(ref_clk),
		.nrstIn(nrst),
		.nrstOut(rstn)
	);

	input_conditioner ch1Cond (
		.clk(ref_clk),
		.rstn(rstn),
		.ce(clkEnable),
		.pinIn(chan1TimerInput),
		.filterLen(s.ic1f),
		.invert(s.cc1p),
		.prescale(2'h0),
		.out(ch1If.src)
	);

	input_conditioner ch2Cond (
		.clk(ref_clk),
		.rstn(rstn),
		.ce(clkEnable),
		.pinIn(chan2TimerInput),
		.filterLen(s.ic2f),
		.invert(s.cc2p),
		.prescale(2'h0),
		.out(ch2If.src)
	);

	input_conditioner extCond (
		.clk(ref_clk),
		.rstn(rstn),
		.ce(clkEnable),
		.pinIn(externalTriggerPin),
		.filterLen(s.etf),
		.invert(s.etp),
		.prescale(s.etps),
		.out(extIf.src)
	);

	function automatic logic addr_mapped(input logic [PADDR_W-1:0] a);
		addr_mapped = (a <= ADDR_CAPTURE1) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [PDATA_W-1:0] read_reg(input logic [PADDR_W-1:0] a, input regs_s r);
		logic [PDATA_W-1:0] d;
		d = '0;
		if (a == ADDR_CTRL) begin
			d[CEN_BIT] = r.cen;
		end else if (a == ADDR_MASTER) begin
			d[MMS_LSB +: 3] = r.mms;
		end else if (a == ADDR_SLAVE) begin
			d[SMS_LSB +: 3] = r.sms;
			d[TS_LSB +: 3] = r.ts;
			d[MSM_BIT] = r.msm;
			d[ETF_LSB +: 4] = r.etf;
			d[ETPS_LSB +: 2] = r.etps;
			d[ECE_BIT] = r.ece;
			d[ETP_BIT] = r.etp;
		end else if (a == ADDR_CHAN) begin
			d[CC1S_LSB +: 2] = r.cc1s;
			d[IC1F_LSB +: 4] = r.ic1f;
			d[CC2S_LSB +: 2] = r.cc2s;
			d[IC2F_LSB +: 4] = r.ic2f;
		end else if (a == ADDR_POLARITY) begin
			d[CC1P_BIT] = r.cc1p;
			d[CC2P_BIT] = r.cc2p;
		end else if (a == ADDR_FLAGS) begin
			d[UIF_BIT] = r.uif;
			d[TIF_BIT] = r.tif;
		end else if (a == ADDR_COUNT) begin
			d[CNT_W-1:0] = r.cnt;
		end else if (a == ADDR_PRESCALE) begin
			d[CNT_W-1:0] = r.psc;
		end else if (a == ADDR_RELOAD) begin
			d[CNT_W-1:0] = r.arr;
		end else if (a == ADDR_COMPARE1) begin
			d[CNT_W-1:0] = r.ccr1;
		end else if (a == ADDR_CAPTURE1) begin
			d[CNT_W-1:0] = r.capt1;
		end
		read_reg = d;
	endfunction

	always_comb begin
		next_s = s;
		setup = psel && !penable;
		wrEn = psel && penable && s.pready && pwrite && addr_mapped(paddr);
		wrCnt = wrEn && (paddr == ADDR_COUNT);
		ugEvent = wrEn && (paddr == ADDR_EVENT) && pwdata[UG_BIT];
		tifClr = wrEn && (paddr == ADDR_FLAGS) && pwdata[TIF_BIT];

		// slave trigger selection; the other timer's output is same-clock logic
		case (s.ts)
			TRIG_INTERNAL: trgiLevel = internalTriggerInput;
			TRIG_CH1_EDGE: trgiLevel = ch1If.rise || ch1If.fall;
			TRIG_CH1: trgiLevel = ch1If.level;
			TRIG_CH2: trgiLevel = ch2If.level;
			TRIG_EXT: trgiLevel = extIf.level;
			default: trgiLevel = 1'b0;
		endcase
		trgiRise = trgiLevel && !s.trgiPrev;
		next_s.trgiPrev = trgiLevel;

		// gating acts on the enable only
		runEnable = s.cen && !((s.sms == SLAVE_GATED) && !trgiLevel);
		next_s.runDly = {s.runDly[MSM_DELAY-2:0], runEnable};
		effRun = s.msm ? s.runDly[MSM_DELAY-1] : runEnable;

		if (s.ece) begin
			countTick = extIf.rise;
		end else if (s.sms == SLAVE_EXTCLK1) begin
			countTick = trgiRise;
		end else begin
			countTick = 1'b1;
		end

		cntStep = 1'b0;
		uevPulse = 1'b0;
		if (effRun && countTick) begin
			if (s.pscCnt == s.psc) begin
				next_s.pscCnt = '0;
				cntStep = 1'b1;
			end else begin
				next_s.pscCnt = s.pscCnt + 1'b1;
			end
		end
		if (cntStep) begin
			if (s.cnt == s.arr) begin
				next_s.cnt = '0;
				uevPulse = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end

		tifSet = 1'b0;
		case (s.sms)
			SLAVE_RESET: begin
				if (trgiRise) begin
					next_s.cnt = '0;
					next_s.pscCnt = '0;
					uevPulse = 1'b1;
					tifSet = 1'b1;
				end
			end
			SLAVE_GATED: begin
				tifSet = trgiRise || (!trgiLevel && s.trgiPrev);
			end
			SLAVE_TRIGGER: begin
				tifSet = trgiRise;
			end
			SLAVE_EXTCLK1: begin
				tifSet = trgiRise;
			end
			default: begin
				tifSet = 1'b0;
			end
		endcase

		if (ugEvent) begin
			next_s.cnt = '0;
			next_s.pscCnt = '0;
			uevPulse = 1'b1;
		end

		// software register writes
		if (wrEn) begin
			if (paddr == ADDR_CTRL) begin
				next_s.cen = pwdata[CEN_BIT];
			end else if (paddr == ADDR_MASTER) begin
				next_s.mms = pwdata[MMS_LSB +: 3];
			end else if (paddr == ADDR_SLAVE) begin
				next_s.sms = pwdata[SMS_LSB +: 3];
				next_s.ts = pwdata[TS_LSB +: 3];
				next_s.msm = pwdata[MSM_BIT];
				next_s.etf = pwdata[ETF_LSB +: 4];
				next_s.etps = pwdata[ETPS_LSB +: 2];
				next_s.ece = pwdata[ECE_BIT];
				next_s.etp = pwdata[ETP_BIT];
			end else if (paddr == ADDR_CHAN) begin
				next_s.cc1s = pwdata[CC1S_LSB +: 2];
				next_s.ic1f = pwdata[IC1F_LSB +: 4];
				next_s.cc2s = pwdata[CC2S_LSB +: 2];
				next_s.ic2f = pwdata[IC2F_LSB +: 4];
			end else if (paddr == ADDR_POLARITY) begin
				next_s.cc1p = pwdata[CC1P_BIT];
				next_s.cc2p = pwdata[CC2P_BIT];
			end else if (paddr == ADDR_COUNT) begin
				next_s.cnt = pwdata[CNT_W-1:0];
			end else if (paddr == ADDR_PRESCALE) begin
				next_s.psc = pwdata[CNT_W-1:0];
			end else if (paddr == ADDR_RELOAD) begin
				next_s.arr = pwdata[CNT_W-1:0];
			end else if (paddr == ADDR_COMPARE1) begin
				next_s.ccr1 = pwdata[CNT_W-1:0];
			end
		end

		// trigger sets the enable after any software write
		if ((s.sms == SLAVE_TRIGGER) && trgiRise) begin
			next_s.cen = 1'b1;
		end

		// flags: hardware set wins over a clear
		next_s.tif = (s.tif && !tifClr) || tifSet;
		next_s.uif = (s.uif && !(wrEn && (paddr == ADDR_FLAGS) && pwdata[UIF_BIT]))
			|| uevPulse;

		// capture on own or neighbouring channel, never prescaled trigger
		if (s.cc1s == CAPSRC_OWN) begin
			capEdge = ch1If.rise;
		end else if (s.cc1s == CAPSRC_OTHER) begin
			capEdge = ch2If.rise;
		end else begin
			capEdge = 1'b0;
		end
		if (capEdge) begin
			next_s.capt1 = s.cnt;
		end

		next_s.ocRef = s.cnt < s.ccr1;
		case (s.mms)
			MASTER_RESET: next_s.trigger_output = ugEvent || ((s.sms == SLAVE_RESET) && trgiRise);
			MASTER_ENABLE: next_s.trigger_output = runEnable;
			MASTER_UPDATE: next_s.trigger_output = uevPulse;
			default: next_s.trigger_output = s.mms[2] && next_s.ocRef;
		endcase

		// zero-wait APB: answer registered in setup cycle
		next_s.pready = setup;
		next_s.pslverr = setup && !addr_mapped(paddr);
		next_s.prdata = (setup && !pwrite) ? read_reg(paddr, s) : '0;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.arr <= RELOAD_RESET;
		end else if (clkEnable) begin
			s <= next_s;
		end
	end

	assign pready = s.pready;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign triggerOutput = s.trigger_output;
	assign chan1CompareReference = s.ocRef;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	property p_trig_start;
		clkEnable && (s.sms == SLAVE_TRIGGER) && trgiRise |=> s.cen && s.tif;
	endproperty
	a_trig_start: assert property (p_trig_start) else $error("trigger did not start counter");

	property p_flag_set_wins;
		clkEnable && tifSet && tifClr |=> s.tif;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("trigger flag lost");

	property p_flag_clear;
		clkEnable && tifClr && !tifSet |=> !s.tif;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("trigger flag not cleared");

	property p_update_trigger_output;
		clkEnable && (s.mms == MASTER_UPDATE) && uevPulse |=> triggerOutput ##1 !triggerOutput[*1];
	endproperty
	a_update_trigger_output: assert property (p_update_trigger_output) else $error("update not on trigger out");

	property p_gated_hold;
		clkEnable && (s.sms == SLAVE_GATED) && !trgiLevel && !s.msm && !wrCnt && !ugEvent
			|=> $stable(s.cnt);
	endproperty
	a_gated_hold: assert property (p_gated_hold) else $error("gated counter moved");

	property p_ug_clears;
		clkEnable && ugEvent |=> (s.cnt == '0) && (s.pscCnt == '0) && s.uif;
	endproperty
	a_ug_clears: assert property (p_ug_clears) else $error("update generation failed");

	property p_cnt_write;
		clkEnable && wrCnt |=> s.cnt == $past(pwdata[CNT_W-1:0]);
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("counter load failed");

	property p_msm_lag;
		clkEnable && s.msm && runEnable && (s.runDly == '0) |=> !effRun;
	endproperty
	a_msm_lag: assert property (p_msm_lag) else $error("master enable not delayed");

	property p_ece_hold;
		clkEnable && s.ece && !extIf.rise && !wrCnt && !ugEvent && (s.sms != SLAVE_RESET)
			|=> $stable(s.pscCnt);
	endproperty
	a_ece_hold: assert property (p_ece_hold) else $error("count without external edge");

	property p_enable_trigger_output;
		clkEnable && (s.mms == MASTER_ENABLE) && !s.cen |=> !triggerOutput;
	endproperty
	a_enable_trigger_output: assert property (p_enable_trigger_output) else $error("enable leaked to trigger out");

	c_trigger_start: cover property (clkEnable && (s.sms == SLAVE_TRIGGER) && trgiRise && !s.cen);
	c_update_out: cover property (triggerOutput && (s.mms == MASTER_UPDATE));
	c_gated_run: cover property ((s.sms == SLAVE_GATED) && trgiLevel && s.cen);
	c_ext_count: cover property (s.ece && extIf.rise && effRun);
endmodule // timer_slave_trigger_and_sync
`default_nettype wire

//--- test/partner_timer.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the other timer on the trigger link
module partner_timer (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic triggerIn,
	output logic triggerOut
);
	int rises;
	logic lastIn;
	initial begin
		triggerOut = 1'b0;
		rises = 0;
		lastIn = 1'b0;
	end
	// partner output feeds our internal trigger input
	task gate(input int n); // level held high for n cycles to gate us
		triggerOut <= 1'b1;
		repeat (n) @(posedge ref_clk);
		triggerOut <= 1'b0;
		@(posedge ref_clk);
	endtask
	task pulses(input int n); // rising edges that clock us
		repeat (n) begin
			triggerOut <= 1'b1;
			repeat (2) @(posedge ref_clk);
			triggerOut <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
	endtask
	always @(posedge ref_clk) begin
		lastIn <= triggerIn;
		if (nrst && triggerIn === 1'b1 && lastIn === 1'b0) begin
			rises <= rises + 1;
		end
	end
endmodule // partner_timer
`default_nettype wire

//--- test/timer_slave_trigger_and_sync_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_slave_trigger_and_sync_tb_top;
	import tsync_pkg::*;
	logic ref_clk, nrst, clkEnable, psel, penable, pwrite, pready, pslverr;
	logic [PADDR_W-1:0] paddr;
	logic [PDATA_W-1:0] pwdata, prdata;
	logic [2:0] pins;
	logic triggerOutput, chan1CompareReference, linkIn;
	int numErrors, checked, cycles, seed, n;
	logic [64:0] expq[$];
	logic [64:0] e;
	logic [31:0] v;

	timer_slave_trigger_and_sync DUT (.ref_clk(ref_clk), .nrst(nrst), .clkEnable(clkEnable),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .chan1TimerInput(pins[0]),
		.chan2TimerInput(pins[1]), .externalTriggerPin(pins[2]),
		.internalTriggerInput(linkIn), .triggerOutput(triggerOutput),
		.chan1CompareReference(chan1CompareReference));
	partner_timer partner (.ref_clk(ref_clk), .nrst(nrst), .triggerIn(triggerOutput),
		.triggerOut(linkIn));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task give_verdict;
		if (numErrors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			numErrors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic err);
		expq.push_back({err, m, d});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wr ? d : 32'h0;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b0, a, d, m, 1'b0);
	endtask

	task pulse(input int k, input int hi, input int lo);
		pins[k] <= 1'b1;
		repeat (hi) @(posedge ref_clk);
		pins[k] <= 1'b0;
		repeat (lo) @(posedge ref_clk);
	endtask

	function logic [31:0] smode(input logic [2:0] ts, input logic [2:0] sms);
		return {25'h0, ts, 1'b0, sms};
	endfunction

	// result watcher: oldest note against what the slave answers
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			numErrors++;
			give_verdict();
		end
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && expq.size() > 0) begin
			e = expq.pop_front();
			check({31'h0, pslverr}, {31'h0, e[64]});
			check(prdata & e[63:32], e[31:0] & e[63:32]);
		end
	end

	initial begin
		nrst = 1'b0;
		clkEnable = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pins = 3'h0;
		numErrors = 0;
		checked = 0;
		cycles = 0;
		seed = 40835;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(ADDR_RELOAD, 32'hffff, 32'hffffffff);
		rd(ADDR_CTRL, 32'h0, 32'hffffffff);
		apb(1'b0, 8'h30, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, 8'h05, 32'h1, 32'h0, 1'b1);
		repeat (4) begin
			v = {16'h0, 16'($random(seed))};
			wr(ADDR_COUNT, v);
			rd(ADDR_COUNT, v, 32'hffff);
		end
		wr(ADDR_EVENT, 32'h1);
		rd(ADDR_COUNT, 32'h0, 32'hffff);
		// channel 2 start in trigger mode, unfiltered, non-inverted, own pin
		wr(ADDR_CHAN, 32'h0101);
		wr(ADDR_SLAVE, smode(TRIG_CH2, SLAVE_TRIGGER));
		pulse(0, 6, 4);
		rd(ADDR_CTRL, 32'h0, 32'h1);
		pulse(1, 6, 6);
		rd(ADDR_CTRL, 32'h1, 32'h1);
		rd(ADDR_FLAGS, 32'h40, 32'h40);
		wr(ADDR_FLAGS, 32'h40);
		rd(ADDR_FLAGS, 32'h0, 32'h40);
		pulse(1, 6, 6);
		rd(ADDR_FLAGS, 32'h40, 32'h40);
		rd(ADDR_CTRL, 32'h1, 32'h1);
		wr(ADDR_CTRL, 32'h0);
		rd(ADDR_CTRL, 32'h0, 32'h1);
		// external clock 2 with channel 1 start; trigger source kept off the ext pin
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_SLAVE, 32'h4000 | smode(TRIG_CH1, SLAVE_TRIGGER));
		pulse(2, 4, 4);
		pulse(2, 4, 4);
		rd(ADDR_COUNT, 32'h0, 32'hffff);
		pulse(0, 6, 6);
		repeat (5) pulse(2, 4, 4);
		repeat (4) @(posedge ref_clk);
		rd(ADDR_COUNT, 32'h5, 32'hffff);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_SLAVE, 32'h0);
		// master output modes seen at the link
		wr(ADDR_MASTER, 32'h10);
		wr(ADDR_CTRL, 32'h1);
		@(posedge ref_clk);
		check({31'h0, triggerOutput}, 32'h1);
		wr(ADDR_CTRL, 32'h0);
		@(posedge ref_clk);
		check({31'h0, triggerOutput}, 32'h0);
		wr(ADDR_MASTER, 32'h40);
		wr(ADDR_COMPARE1, 32'h5);
		wr(ADDR_COUNT, 32'h2);
		@(posedge ref_clk);
		check({31'h0, triggerOutput}, 32'h1);
		check({31'h0, chan1CompareReference}, 32'h1);
		wr(ADDR_COUNT, 32'h9);
		@(posedge ref_clk);
		check({31'h0, triggerOutput}, 32'h0);
		check({31'h0, chan1CompareReference}, 32'h0);
		wr(ADDR_MASTER, 32'h20);
		wr(ADDR_RELOAD, 32'h3);
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_CTRL, 32'h1);
		n = 0;
		while (triggerOutput !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		check({31'h0, triggerOutput}, 32'h0);
		n = 1;
		while (triggerOutput !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		check(32'(n), 32'h4);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_RELOAD, 32'hffff);
		// slave fed by the partner over the internal link
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_SLAVE, smode(TRIG_INTERNAL, SLAVE_GATED));
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_COUNT, 32'h0, 32'hffff);
		partner.gate(20);
		repeat (4) @(posedge ref_clk);
		rd(ADDR_COUNT, 32'd20, 32'hffff);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_SLAVE, smode(TRIG_INTERNAL, SLAVE_EXTCLK1));
		wr(ADDR_CTRL, 32'h1);
		// frozen while the clock enable is low: these edges must not count
		clkEnable <= 1'b0;
		partner.pulses(2);
		clkEnable <= 1'b1;
		partner.pulses(5);
		repeat (4) @(posedge ref_clk);
		rd(ADDR_COUNT, 32'h5, 32'hffff);
		repeat (2) @(posedge ref_clk);
		give_verdict();
	end
endmodule // timer_slave_trigger_and_sync_tb_top
`default_nettype wire
